/* rtl/dcr_pkg.sv */
// Constants and types shared by the DMA channel control register block
package dcr_pkg;
  localparam int unsigned NCH = 5;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 8;
  localparam int unsigned PW = 16;
  // Register addresses in special function register space
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'hD1;
  localparam logic [7:0] ADDR_CH14_PTR_LO = 8'hD2;
  localparam logic [7:0] ADDR_CH14_PTR_HI = 8'hD3;
  localparam logic [7:0] ADDR_CH0_PTR_LO = 8'hD4;
  localparam logic [7:0] ADDR_CH0_PTR_HI = 8'hD5;
  localparam logic [7:0] ADDR_ARM_ABORT = 8'hD6;
  localparam logic [7:0] ADDR_MAN_TRIG = 8'hD7;
  // Field positions
  localparam int unsigned ABORT_BIT = 7;
  localparam int unsigned CH_MSB = 4;
  // Reset values and the first channel that uses the shared pointer
  localparam logic [4:0] CH_RST = 5'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [2:0] CH_FIRST_SHARED = 3'h1;
  // Bytes per configuration structure in memory
  localparam logic [15:0] CFG_BYTES = 16'h0008;
  typedef logic [NCH-1:0] dcr_ch_t;
  typedef logic [PW-1:0] dcr_ptr_t;
  typedef enum logic [1:0] {CA_IDLE, CA_BUSY} dcr_ca_e;
endpackage : dcr_pkg

/* rtl/dcr_cfg_if.sv */
// Interface carrying pointers and channel select to the address generator
`timescale 1ns/1ps
`default_nettype none
interface dcr_cfg_if;
  import dcr_pkg::*;
  dcr_ptr_t ptr0;
  dcr_ptr_t ptr14;
  logic [2:0] ch_sel;
  dcr_ptr_t cfg_addr;
  modport regs (output ptr0, output ptr14, output ch_sel, input cfg_addr);
  modport gen (input ptr0, input ptr14, input ch_sel, output cfg_addr);
endinterface : dcr_cfg_if
`default_nettype wire

/* rtl/dcr_cfg_addr.sv */
// Configuration structure address generator for the selected channel
`timescale 1ns/1ps
`default_nettype none
module dcr_cfg_addr
  import dcr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  dcr_cfg_if.gen cfg
);
  typedef struct packed {
    dcr_ptr_t addr;
  } dcr_ca_s;

  dcr_ca_s st_r;
  dcr_ca_s st_nxt;
  logic [2:0] off_idx;

  // -----------------------------------------------------------------
  // Address select
  // -----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    off_idx = cfg.ch_sel - CH_FIRST_SHARED;
    if (cfg.ch_sel == 3'h0) begin
      st_nxt.addr = cfg.ptr0;
    end else begin
      // Shared structures sit back to back in channel order
      st_nxt.addr = 16'(cfg.ptr14 + 16'(off_idx) * CFG_BYTES);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{addr: PTR_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg.cfg_addr = st_r.addr;

  shared_layout_a: assert property (@(posedge clk) disable iff (!rstn)
    (cfg.ch_sel != 3'h0) |=> (cfg.cfg_addr == 16'($past(cfg.ptr14)
      + 16'($past(cfg.ch_sel) - CH_FIRST_SHARED) * CFG_BYTES)))
    else $error("shared config address not consecutive");
endmodule : dcr_cfg_addr
`default_nettype wire

/* rtl/dcr_regs.sv */
// DMA channel arm, manual trigger, done flag and pointer registers
`timescale 1ns/1ps
`default_nettype none
module dcr_regs
  import dcr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [AW-1:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [DW-1:0] sfr_wdata,
  output logic [DW-1:0] sfr_rdata,
  input wire logic [NCH-1:0] ch_grant,
  input wire logic [NCH-1:0] ch_count_done,
  input wire logic [NCH-1:0] ch_repetitive,
  input wire logic [NCH-1:0] channel_irq_enable,
  input wire logic [NCH-1:0] ch_trig_sel_zero,
  input wire logic [NCH-1:0] ch_ext_trigger,
  input wire logic [2:0] ch_sel,
  output logic [NCH-1:0] channel_arm_bit,
  output logic [NCH-1:0] ch_request,
  output logic [NCH-1:0] ch_abort,
  output logic dma_irq,
  output logic [PW-1:0] cfg_addr
);
  typedef struct packed {
    dcr_ch_t arm;
    dcr_ch_t req;
    dcr_ch_t flags;
    dcr_ch_t abort;
    dcr_ptr_t ptr0;
    dcr_ptr_t ptr14;
    logic [DW-1:0] rdata;
  } dcr_st_s;

  dcr_st_s st_r;
  dcr_st_s st_nxt;
  dcr_ch_t wr_ch;
  logic wr_arm;
  logic wr_req;
  logic wr_irq;
  logic abort_wr;

  dcr_cfg_if cfg ();

  assign wr_ch = sfr_wdata[CH_MSB:0];
  assign wr_arm = sfr_wr && (sfr_addr == ADDR_ARM_ABORT);
  assign wr_req = sfr_wr && (sfr_addr == ADDR_MAN_TRIG);
  assign wr_irq = sfr_wr && (sfr_addr == ADDR_IRQ_FLAGS);
  assign abort_wr = wr_arm && sfr_wdata[ABORT_BIT];

  // -----------------------------------------------------------------
  // Register next state
  // -----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.abort = CH_RST;
    // Hardware clear first so that a software set in the same cycle wins
    st_nxt.arm = st_r.arm & ~(ch_count_done & ~ch_repetitive);
    if (abort_wr) begin
      st_nxt.arm = st_nxt.arm & ~wr_ch;
      st_nxt.abort = wr_ch;
    end else if (wr_arm) begin
      st_nxt.arm = wr_ch;
    end
    st_nxt.req = st_r.req & ~ch_grant;
    if (wr_req) begin
      st_nxt.req = st_nxt.req | wr_ch;
    end
    st_nxt.flags = st_r.flags;
    if (wr_irq) begin
      st_nxt.flags = st_r.flags & wr_ch;
    end
    st_nxt.flags = st_nxt.flags | ch_count_done;
    if (sfr_wr) begin
      case (sfr_addr)
        ADDR_CH0_PTR_HI: st_nxt.ptr0[15:8] = sfr_wdata;
        ADDR_CH0_PTR_LO: st_nxt.ptr0[7:0] = sfr_wdata;
        ADDR_CH14_PTR_HI: st_nxt.ptr14[15:8] = sfr_wdata;
        ADDR_CH14_PTR_LO: st_nxt.ptr14[7:0] = sfr_wdata;
        default: ;
      endcase
    end
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_IRQ_FLAGS: st_nxt.rdata = DW'(st_r.flags);
        ADDR_CH14_PTR_LO: st_nxt.rdata = st_r.ptr14[7:0];
        ADDR_CH14_PTR_HI: st_nxt.rdata = st_r.ptr14[15:8];
        ADDR_CH0_PTR_LO: st_nxt.rdata = st_r.ptr0[7:0];
        ADDR_CH0_PTR_HI: st_nxt.rdata = st_r.ptr0[15:8];
        // Abort bit is write-only and reads back as zero
        ADDR_ARM_ABORT: st_nxt.rdata = DW'(st_r.arm);
        ADDR_MAN_TRIG: st_nxt.rdata = DW'(st_r.req);
        default: st_nxt.rdata = BYTE_RST;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{arm: CH_RST, req: CH_RST, flags: CH_RST, abort: CH_RST,
                ptr0: PTR_RST, ptr14: PTR_RST, rdata: BYTE_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Engine side
  // -----------------------------------------------------------------
  // External triggers are ignored for channels with selection zero
  assign ch_request = st_r.arm
    & (st_r.req | (ch_ext_trigger & ~ch_trig_sel_zero));
  assign channel_arm_bit = st_r.arm;
  assign ch_abort = st_r.abort;
  assign dma_irq = |(st_r.flags & channel_irq_enable);
  assign sfr_rdata = st_r.rdata;

  assign cfg.ptr0 = st_r.ptr0;
  assign cfg.ptr14 = st_r.ptr14;
  assign cfg.ch_sel = ch_sel;
  assign cfg_addr = cfg.cfg_addr;

  dcr_cfg_addr u_cfg_addr (
    .clk(clk),
    .rstn(rstn),
    .cfg(cfg)
  );

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  abort_disarm_a: assert property (@(posedge clk) disable iff (!rstn)
    abort_wr |=> ((channel_arm_bit & $past(wr_ch)) == CH_RST)
      && (ch_abort == $past(wr_ch)))
    else $error("abort did not disarm selected channels");

  abort_reads_zero_a: assert property (@(posedge clk)
    disable iff (!rstn)
    (sfr_rd && sfr_addr == ADDR_ARM_ABORT) |=> !sfr_rdata[ABORT_BIT])
    else $error("abort bit read back as one");

  armed_only_a: assert property (@(posedge clk) disable iff (!rstn)
    (ch_request & ~channel_arm_bit) == CH_RST)
    else $error("request on a disarmed channel");

  auto_disarm_a: assert property (@(posedge clk) disable iff (!rstn)
    (!wr_arm && (ch_count_done & ~ch_repetitive) != CH_RST)
      |=> ((channel_arm_bit & $past(ch_count_done & ~ch_repetitive))
        == CH_RST))
    else $error("arm bit kept after count reached");

  manual_trig_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_req |=> ((st_r.req & $past(wr_ch)) == $past(wr_ch))
      ##0 ((ch_request & channel_arm_bit & $past(wr_ch))
        == (channel_arm_bit & $past(wr_ch))))
    else $error("manual trigger not raised");

  grant_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    (!wr_req && ch_grant != CH_RST)
      |=> ((st_r.req & $past(ch_grant)) == CH_RST))
    else $error("grant did not clear request");

  ptr0_write_a: assert property (@(posedge clk) disable iff (!rstn)
    (sfr_wr && sfr_addr == ADDR_CH0_PTR_HI)
      |=> (st_r.ptr0[15:8] == $past(sfr_wdata))
        && (st_r.ptr0[7:0] == $past(st_r.ptr0[7:0])))
    else $error("channel 0 pointer high byte not stored");

  ptr14_write_a: assert property (@(posedge clk) disable iff (!rstn)
    (sfr_wr && sfr_addr == ADDR_CH14_PTR_LO)
      |=> (st_r.ptr14[7:0] == $past(sfr_wdata)))
    else $error("shared pointer low byte not stored");

  flag_set_a: assert property (@(posedge clk) disable iff (!rstn)
    (ch_count_done != CH_RST)
      |=> ((st_r.flags & $past(ch_count_done)) == $past(ch_count_done)))
    else $error("done flag not set");

  flag_w1_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr_irq && ch_count_done == CH_RST)
      |=> (st_r.flags == ($past(st_r.flags) & $past(wr_ch))))
    else $error("flag write not clear-only");

  irq_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    ((st_r.flags & channel_irq_enable) == CH_RST) |-> !dma_irq)
    else $error("interrupt without enabled flag");

  sel_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    (ch_request & ch_trig_sel_zero & ~st_r.req) == CH_RST)
    else $error("external trigger with selection zero");

  ptr0_low_write_a: assert property (@(posedge clk)
    disable iff (!rstn)
    (sfr_wr && sfr_addr == ADDR_CH0_PTR_LO)
      |=> (st_r.ptr0[7:0] == $past(sfr_wdata)))
    else $error("channel 0 pointer low byte not stored");

  ptr14_high_write_a: assert property (@(posedge clk)
    disable iff (!rstn)
    (sfr_wr && sfr_addr == ADDR_CH14_PTR_HI)
      |=> (st_r.ptr14[15:8] == $past(sfr_wdata)))
    else $error("shared pointer high byte not stored");

  abort_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    !abort_wr |=> (ch_abort == CH_RST))
    else $error("abort pulse without an abort write");

  arm_write_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr_arm && !abort_wr) |=> (channel_arm_bit == $past(wr_ch)))
    else $error("arm bits not loaded by a write");

  flag_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !wr_irq |=> ((st_r.flags & $past(st_r.flags)) == $past(st_r.flags)))
    else $error("done flag lost without a clear write");

  irq_raise_a: assert property (@(posedge clk) disable iff (!rstn)
    ((st_r.flags & channel_irq_enable) != CH_RST) |-> dma_irq)
    else $error("enabled flag raised no interrupt");
endmodule : dcr_regs
`default_nettype wire

/* tb/dcr_engine_model.sv */
// Behavioural transfer arbiter that grants pending channel requests
`timescale 1ns/1ps
`default_nettype none
module dcr_engine_model
  import dcr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic grant_en,
  input wire logic [NCH-1:0] ch_request,
  output logic [NCH-1:0] ch_grant
);
  // Lowest channel wins; grant_en low models a slow arbiter.
  // Never grants two cycles running, so a cleared request can drop first.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ch_grant <= '0;
    end else if (grant_en && ch_grant == '0) begin
      ch_grant <= ch_request & (~ch_request + 5'h01);
    end else begin
      ch_grant <= '0;
    end
  end
endmodule : dcr_engine_model
`default_nettype wire

/* tb/dma_channel_control_regs_tb_top.sv */
// Self-checking bench for the DMA channel control registers
`timescale 1ns/1ps
`default_nettype none
module dma_channel_control_regs_tb_top
  import dcr_pkg::*;
();
  logic clk = 1'b0, rstn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic grant_en = 1'b0, dma_irq;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [2:0] ch_sel = 3'h0;
  logic [4:0] done = 5'h00, rep = 5'h00, irq_en = 5'h00, sel0 = 5'h00;
  logic [4:0] ext = 5'h00, grant, arm, req, abrt;
  logic [15:0] cfg_addr;
  logic [23:0] rows [8] = '{24'hD2A5A5, 24'hD33C3C, 24'hD45A5A, 24'hD5C3C3,
    24'hD61F1F, 24'hD8FF00, 24'hD0FF00, 24'hD7E000};
  int n_fail = 0, comparisons = 0, cycles = 0;
  always #50 clk = ~clk;
  dcr_regs dcr_regs_i (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .ch_grant(grant), .ch_count_done(done),
    .ch_repetitive(rep), .channel_irq_enable(irq_en),
    .ch_trig_sel_zero(sel0), .ch_ext_trigger(ext), .ch_sel(ch_sel),
    .channel_arm_bit(arm), .ch_request(req), .ch_abort(abrt),
    .dma_irq(dma_irq), .cfg_addr(cfg_addr));
  dcr_engine_model dcr_engine_model_i (.clk(clk), .rstn(rstn),
    .grant_en(grant_en), .ch_request(req), .ch_grant(grant));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk("sfr_rdata", {8'h00, sfr_rdata}, {8'h00, e});
  endtask : rd
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    for (int a = 8'hD1; a <= 8'hD7; a++) rd(8'(a), 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    for (int n = 0; n < 5; n++) begin
      @(negedge clk) ch_sel = 3'(n);
      @(negedge clk);
      chk("cfg_addr", cfg_addr, (n == 0) ? 16'hC35A
        : 16'h3CA5 + CFG_BYTES * 16'(n - 1));
    end
    wr(8'hD6, 8'h81);
    chk("ch_abort", {11'h000, abrt}, 16'h0001);
    chk("arm", {11'h000, arm}, 16'h001E);
    rd(8'hD6, 8'h1E);
    chk("ch_abort", {11'h000, abrt}, 16'h0000);
    rep = 5'h02;
    irq_en = 5'h04;
    @(negedge clk) done = 5'h06;
    @(negedge clk) done = 5'h00;
    chk("arm", {11'h000, arm}, 16'h001A);
    chk("dma_irq", {15'h0000, dma_irq}, 16'h0001);
    irq_en = 5'h01;
    #1 chk("dma_irq", {15'h0000, dma_irq}, 16'h0000);
    rd(8'hD1, 8'h06);
    wr(8'hD1, 8'h1B);
    rd(8'hD1, 8'h02);
    sel0 = 5'h1F;
    wr(8'hD7, 8'h08);
    ext = 5'h10;
    #1 chk("ch_request", {11'h000, req}, 16'h0008);
    @(negedge clk) sel0 = 5'h0F;
    #1 chk("ch_request", {11'h000, req}, 16'h0018);
    @(negedge clk) ext = 5'h00;
    wr(8'hD7, 8'h00);
    rd(8'hD7, 8'h08);
    grant_en = 1'b1;
    for (int k = 0; k < 10 && req !== 5'h00; k++) @(negedge clk);
    rd(8'hD7, 8'h00);
    wr(8'hD7, 8'h04);
    chk("ch_request", {11'h000, req}, 16'h0000);
    rd(8'hD7, 8'h04);
    // ----------------------------------------
    // Awkward cases
    // ----------------------------------------
    // Count reached in the cycle of a clear write: the set wins
    @(negedge clk);
    sfr_addr = 8'hD1;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b1;
    done = 5'h01;
    @(negedge clk);
    sfr_wr = 1'b0;
    done = 5'h00;
    chk("dma_irq", {15'h0000, dma_irq}, 16'h0001);
    rd(8'hD1, 8'h01);
    // Arm write in the cycle of a count reached keeps the written value
    @(negedge clk);
    sfr_addr = 8'hD6;
    sfr_wdata = 8'h1F;
    sfr_wr = 1'b1;
    done = 5'h10;
    @(negedge clk);
    sfr_wr = 1'b0;
    done = 5'h00;
    chk("arm", {11'h000, arm}, 16'h001F);
    rd(8'hD1, 8'h11);
    // Reset in mid-run clears every register at once
    @(negedge clk) rstn = 1'b0;
    #1 chk("arm", {11'h000, arm}, 16'h0000);
    chk("ch_request", {11'h000, req}, 16'h0000);
    chk("dma_irq", {15'h0000, dma_irq}, 16'h0000);
    chk("cfg_addr", cfg_addr, 16'h0000);
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk("cfg_addr", cfg_addr, CFG_BYTES * 16'h0003);
    for (int a = 8'hD1; a <= 8'hD7; a++) rd(8'(a), 8'h00);
    tally_and_finish();
  end
endmodule : dma_channel_control_regs_tb_top
`default_nettype wire
